// ==== inc/stc_pkg.sv ====
// Package for the sixteen-bit timer/counter: register offsets, field positions and reset values.
// Assumes a single 10 MHz system clock and a plain strobe register port.
package stc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] STC_OFF_CONTROL   = 3'h0;
  localparam logic [2:0] STC_OFF_COUNT_LOW = 3'h1;
  localparam logic [2:0] STC_OFF_COUNT_HI  = 3'h2;
  localparam logic [2:0] STC_OFF_FLAGS     = 3'h3;
  localparam logic [2:0] STC_OFF_ENABLES   = 3'h4;
  localparam logic [2:0] STC_OFF_OSC_CTRL  = 3'h5;
  localparam logic [2:0] STC_OFF_PORT_DIR  = 3'h6;
  localparam logic [2:0] STC_OFF_PORT_IN   = 3'h7;

  // ----------------------------------------------------------------
  // Control, flag and enable register fields
  // ----------------------------------------------------------------
  localparam int STC_BIT_WIDE      = 7;
  localparam int STC_BIT_RUNSTAT   = 6;
  localparam int STC_BIT_PS_HI     = 5;
  localparam int STC_BIT_PS_LO     = 4;
  localparam int STC_BIT_OSC_EN    = 3;
  localparam int STC_BIT_SYNC_DIS  = 2;
  localparam int STC_BIT_CLK_SRC   = 1;
  localparam int STC_BIT_ON        = 0;
  localparam int STC_BIT_OVF       = 0;

  localparam logic [7:0] STC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] STC_CONTROL_WMASK = 8'hbf;
  localparam logic [1:0] STC_SCS_AUX_OSC   = 2'h1;
  localparam logic [1:0] STC_PIN_MASK      = 2'h3;

  // Internal instruction clock is the system clock divided by four.
  localparam int         STC_INSTR_DIV     = 4;
  localparam logic [1:0] STC_INSTR_LAST    = 2'(STC_INSTR_DIV - 1);

endpackage : stc_pkg

// ==== rtl/stc_timer.sv ====
// Sixteen-bit timer/counter with prescaler, clock source choice and overflow interrupt.
// Assumes the external pin and oscillator inputs are synchronous to i_clock.
// Register reads answer in the cycle after the read strobe; writes land at the strobe edge.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns

module stc_timer
  import stc_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_ext_clk_pin,
  input  wire logic       i_osc_in_pin,
  input  wire logic       i_power_managed,
  output logic            o_osc_run,
  output logic            o_sys_clk_from_aux,
  output logic      [1:0] o_pin_oe,
  output logic            o_irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] high_buffer_reg;
  logic       overflow_flag_reg;
  logic       overflow_irq_enable_reg;
  logic [1:0] system_clock_select_reg;
  logic [1:0] port_direction_reg;
  logic [1:0] instr_div_reg;
  logic [2:0] prescale_reg;
  logic       ext_sync1_reg;
  logic       ext_sync2_reg;
  logic       ext_prev_reg;

  logic       wide_access_enable;
  logic [1:0] input_prescale_select;
  logic       aux_osc_enable;
  logic       ext_sync_disable;
  logic       clock_source_select;
  logic       counter_on;
  logic       aux_osc_clock_status;

  logic       wr_low;
  logic       wr_high;
  logic       rd_low;
  logic       wr_control;
  logic       wr_flags;
  logic       wr_enables;
  logic       wr_osc_ctrl;
  logic       wr_port_dir;
  logic       instr_tick;
  logic       ext_level;
  logic       ext_rise;
  logic       src_tick;
  logic       prescale_out;
  logic       count_tick;
  logic       wrap;
  logic       low_carry;
  logic [2:0] prescale_last;
  logic [7:0] pin_read;
  logic [7:0] rdata_next;

  // ----------------------------------------------------------------
  // Prescale terminal count
  // ----------------------------------------------------------------
  function automatic logic [2:0] stc_ps_last(input logic [1:0] sel);
    stc_ps_last = 3'(({2'h0, 1'b1} << sel) - 3'h1);
  endfunction

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign wide_access_enable    = control_reg[STC_BIT_WIDE];
  assign input_prescale_select = control_reg[STC_BIT_PS_HI:STC_BIT_PS_LO];
  assign aux_osc_enable        = control_reg[STC_BIT_OSC_EN];
  assign ext_sync_disable      = control_reg[STC_BIT_SYNC_DIS];
  assign clock_source_select   = control_reg[STC_BIT_CLK_SRC];
  assign counter_on            = control_reg[STC_BIT_ON];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic stc_hit(input logic       strobe,
                                   input logic [2:0] addr,
                                   input logic [2:0] offset);
    stc_hit = strobe && (addr == offset);
  endfunction

  assign wr_control  = stc_hit(i_wr, i_addr, STC_OFF_CONTROL);
  assign wr_low      = stc_hit(i_wr, i_addr, STC_OFF_COUNT_LOW);
  assign wr_high     = stc_hit(i_wr, i_addr, STC_OFF_COUNT_HI);
  assign wr_flags    = stc_hit(i_wr, i_addr, STC_OFF_FLAGS);
  assign wr_enables  = stc_hit(i_wr, i_addr, STC_OFF_ENABLES);
  assign wr_osc_ctrl = stc_hit(i_wr, i_addr, STC_OFF_OSC_CTRL);
  assign wr_port_dir = stc_hit(i_wr, i_addr, STC_OFF_PORT_DIR);
  assign rd_low      = stc_hit(i_rd, i_addr, STC_OFF_COUNT_LOW);

  // ----------------------------------------------------------------
  // Oscillator and system clock status
  // ----------------------------------------------------------------
  // The power-managed input has no effect on the oscillator on purpose.
  assign o_osc_run            = aux_osc_enable;
  assign aux_osc_clock_status = (system_clock_select_reg == STC_SCS_AUX_OSC);
  assign o_sys_clk_from_aux   = aux_osc_clock_status;

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // A running counter owns both pins, so its direction bits matter only while it is stopped.
  assign o_pin_oe = counter_on ? 2'h0 : ~port_direction_reg;
  assign pin_read = counter_on ? 8'h00 : {6'h00, i_osc_in_pin, i_ext_clk_pin};

  // ----------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      instr_div_reg <= 2'h0;
    end else if (instr_tick) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  // The divider runs free from reset, whether or not the counter is on, so the
  // first internal tick after switching on arrives within four clocks.
  assign instr_tick = (instr_div_reg == STC_INSTR_LAST);

  // The oscillator input counts only while the oscillator runs.
  assign ext_level = i_ext_clk_pin | (aux_osc_enable & i_osc_in_pin);

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_level;
      ext_sync2_reg <= ext_sync1_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_sync_disable ? ext_level : ext_sync2_reg;
    end
  end

  // The unsynchronised path saves two cycles of latency, since inputs are
  // already synchronous; the synchronised path passes two flip-flops.
  assign ext_rise = ext_sync_disable ? (ext_level & ~ext_prev_reg)
                                     : (ext_sync2_reg & ~ext_prev_reg);
  assign src_tick = clock_source_select ? ext_rise : instr_tick;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign prescale_last = stc_ps_last(input_prescale_select);
  assign prescale_out  = src_tick && (prescale_reg >= prescale_last);
  // A low-byte write wins over a count in the same cycle, so no carry or
  // overflow comes from a value that software has just overwritten.
  assign count_tick    = counter_on && prescale_out && !wr_low;
  assign low_carry     = count_tick && (count_low_reg == 8'hff);
  assign wrap          = low_carry && (count_high_reg == 8'hff);

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      prescale_reg <= 3'h0;
    end else if (wr_low) begin
      prescale_reg <= 3'h0;
    end else if (counter_on && prescale_out) begin
      prescale_reg <= 3'h0;
    end else if (counter_on && src_tick) begin
      prescale_reg <= prescale_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Count pair and high-byte buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      count_low_reg <= 8'h00;
    end else if (wr_low) begin
      count_low_reg <= i_wdata;
    end else if (count_tick) begin
      count_low_reg <= count_low_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      count_high_reg <= 8'h00;
    end else if (wr_low && wide_access_enable) begin
      count_high_reg <= high_buffer_reg;
    end else if (wr_high && !wide_access_enable) begin
      count_high_reg <= i_wdata;
    end else if (low_carry) begin
      count_high_reg <= count_high_reg + 8'h01;
    end
  end

  // The buffer is caught by a low-byte read, so software reads low first and then
  // high to see one coherent 16-bit value across a rollover.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      high_buffer_reg <= 8'h00;
    end else if (wide_access_enable && wr_high) begin
      high_buffer_reg <= i_wdata;
    end else if (wide_access_enable && rd_low) begin
      high_buffer_reg <= count_high_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control, flag and enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      control_reg <= STC_CONTROL_RESET;
    end else if (wr_control) begin
      control_reg <= i_wdata & STC_CONTROL_WMASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      overflow_flag_reg <= 1'b0;
    end else if (wrap) begin
      // A wrap and a clear in one cycle leave the flag set, so no overflow is lost.
      overflow_flag_reg <= 1'b1;
    end else if (wr_flags && i_wdata[STC_BIT_OVF]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      overflow_irq_enable_reg <= 1'b0;
    end else if (wr_enables) begin
      overflow_irq_enable_reg <= i_wdata[STC_BIT_OVF];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      system_clock_select_reg <= 2'h0;
    end else if (wr_osc_ctrl) begin
      system_clock_select_reg <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      port_direction_reg <= STC_PIN_MASK;
    end else if (wr_port_dir) begin
      port_direction_reg <= i_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  assign o_irq = overflow_flag_reg && overflow_irq_enable_reg;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    case (i_addr)
      STC_OFF_CONTROL: begin
        rdata_next = control_reg;
        rdata_next[STC_BIT_RUNSTAT] = aux_osc_clock_status;
      end
      STC_OFF_COUNT_LOW: begin
        rdata_next = count_low_reg;
      end
      STC_OFF_COUNT_HI: begin
        rdata_next = wide_access_enable ? high_buffer_reg : count_high_reg;
      end
      STC_OFF_FLAGS: begin
        rdata_next = {7'h00, overflow_flag_reg};
      end
      STC_OFF_ENABLES: begin
        rdata_next = {7'h00, overflow_irq_enable_reg};
      end
      STC_OFF_OSC_CTRL: begin
        rdata_next = {6'h00, system_clock_select_reg};
      end
      STC_OFF_PORT_DIR: begin
        rdata_next = {6'h00, port_direction_reg};
      end
      STC_OFF_PORT_IN: begin
        rdata_next = pin_read;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data stand for one cycle and then return to zero, so a stale value is
  // never mistaken for the answer to a later read.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // stc_timer

// ==== testbench/stc_timer_props.sv ====
// Checker for the timer/counter: ties its outputs to register traffic.
// Assumes one clock and the synchronous active-low reset of the block.
`timescale 1ns/1ns
module stc_timer_props
  import stc_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_ext_clk_pin,
  input wire logic       i_osc_in_pin,
  input wire logic       i_power_managed,
  input wire logic       o_osc_run,
  input wire logic       o_sys_clk_from_aux,
  input wire logic [1:0] o_pin_oe,
  input wire logic       o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic ctl_wr;
  logic osc_wr;
  assign ctl_wr = i_wr && i_addr == STC_OFF_CONTROL;
  assign osc_wr = i_wr && i_addr == STC_OFF_OSC_CTRL;
  AST_OSC_ENABLE: assert property (ctl_wr ##1 !ctl_wr
    |=> o_osc_run == $past(i_wdata[STC_BIT_OSC_EN], 2)) else $error("oscillator run wrong");
  AST_OSC_HOLD: assert property (!ctl_wr ##1 !ctl_wr |=> $stable(o_osc_run))
    else $error("oscillator run moved without a control write");
  AST_SYS_CLK: assert property (osc_wr ##1 !osc_wr
    |=> o_sys_clk_from_aux == ($past(i_wdata[1:0], 2) == STC_SCS_AUX_OSC)) else $error("clock select");
  AST_RUN_STATUS: assert property (i_rd && i_addr == STC_OFF_CONTROL && !osc_wr && !$past(osc_wr)
    |=> o_rdata[STC_BIT_RUNSTAT] == $past(o_sys_clk_from_aux)) else $error("status bit wrong");
  AST_PINS_INPUT: assert property (ctl_wr && i_wdata[STC_BIT_ON] ##1 !ctl_wr
    |=> o_pin_oe == 2'h0) else $error("pins driven while counting");
  AST_IRQ_ENABLE: assert property (i_rd && i_addr == STC_OFF_ENABLES && o_irq
    |=> o_rdata[STC_BIT_OVF]) else $error("interrupt without enable");
  AST_IRQ_FLAG: assert property (i_rd && i_addr == STC_OFF_FLAGS && o_irq
    |=> o_rdata[STC_BIT_OVF]) else $error("interrupt without flag");
  AST_RESET_STATE: assert property ($rose(i_rst_b)
    |-> !o_osc_run && !o_irq && !o_sys_clk_from_aux && o_rdata == 8'h00) else $error("reset state");
  cover property (o_irq);
  cover property (ctl_wr && i_wdata[STC_BIT_ON]);
  cover property (o_sys_clk_from_aux);
endmodule // stc_timer_props

bind stc_timer stc_timer_props u_props (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk_pin(i_ext_clk_pin),
  .i_osc_in_pin(i_osc_in_pin), .i_power_managed(i_power_managed), .o_osc_run(o_osc_run),
  .o_sys_clk_from_aux(o_sys_clk_from_aux), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

// ==== testbench/stc_clock_source.sv ====
// Model of the external count pin and the crystal input.
// Assumes the caller starts a burst just after a rising clock edge.
`timescale 1ns/1ns
module stc_clock_source (
  input  wire logic i_clock,
  output logic      o_ext_clk_pin,
  output logic      o_osc_in_pin
);
  // Both lines stand low between bursts, as a stopped crystal or idle pin would.
  initial begin
    o_ext_clk_pin = 1'b0;
    o_osc_in_pin = 1'b0;
  end
  task automatic pulses(input int n, input logic use_osc, input int half);
    repeat (n) begin
      if (use_osc) o_osc_in_pin <= 1'b1;
      else o_ext_clk_pin <= 1'b1;
      repeat (half) @(posedge i_clock);
      o_osc_in_pin <= 1'b0;
      o_ext_clk_pin <= 1'b0;
      repeat (half) @(posedge i_clock);
    end
  endtask
  task automatic hold(input logic ext, input logic osc);
    o_ext_clk_pin <= ext;
    o_osc_in_pin <= osc;
    @(posedge i_clock);
  endtask
endmodule // stc_clock_source

// ==== testbench/testbench.sv ====
// Self-checking bench for the timer/counter: registers, counting and interrupt.
// Assumes the clock source model drives both count inputs.
`timescale 1ns/1ns
module testbench;
  import stc_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rst_b = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_power_managed = 1'b0;
  logic [7:0] o_rdata;
  logic       ext_pin, osc_pin, o_osc_run, o_sys_clk_from_aux, o_irq;
  logic [1:0] o_pin_oe;
  int         errors = 0, checks_done = 0, seed = 52, n, k;
  stc_clock_source i_src (.i_clock(i_clock), .o_ext_clk_pin(ext_pin), .o_osc_in_pin(osc_pin));
  stc_timer i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk_pin(ext_pin),
    .i_osc_in_pin(osc_pin), .i_power_managed(i_power_managed), .o_osc_run(o_osc_run),
    .o_sys_clk_from_aux(o_sys_clk_from_aux), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
  always #50 i_clock = ~i_clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Each access leaves one idle edge so a strobe is never set and cleared in one step.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
    @(posedge i_clock);
  endtask
  function automatic logic [7:0] scaled(input int edges, input logic [1:0] ps);
    return 8'(edges >> ps);
  endfunction
  initial begin
    repeat (60000) @(posedge i_clock);
    errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    rdchk(STC_OFF_CONTROL, STC_CONTROL_RESET);
    wr(STC_OFF_CONTROL, 8'hfe);
    rdchk(STC_OFF_CONTROL, 8'hbe);
    for (k = 0; k < 6; k++) begin
      n = $random(seed);
      if (k == 0) n[1:0] = 2'b01;
      i_power_managed <= n[8];
      wr(STC_OFF_OSC_CTRL, n[7:0]);
      @(posedge i_clock);
      check({7'h0, o_sys_clk_from_aux}, {7'h0, n[1:0] == STC_SCS_AUX_OSC});
      check({7'h0, o_osc_run}, 8'h01);
      rdchk(STC_OFF_CONTROL, {1'b1, n[1:0] == STC_SCS_AUX_OSC, 6'h3e});
    end
    for (k = 0; k < 8; k++) begin
      n = 3 + ($random(seed) & 15);
      wr(STC_OFF_CONTROL, {2'b00, k[1:0], 1'b0, k[2], 2'b11});
      wr(STC_OFF_COUNT_LOW, 8'h00);
      i_src.pulses(n, 1'b0, 2 + k[0]);
      repeat (4) @(posedge i_clock);
      rdchk(STC_OFF_COUNT_LOW, scaled(n, k[1:0]));
    end
    for (k = 0; k < 3; k++) begin
      wr(STC_OFF_CONTROL, {4'h0, k == 1, 2'b11, k < 2});
      wr(STC_OFF_COUNT_LOW, 8'h00);
      i_src.pulses(5, k < 2, 2);
      rdchk(STC_OFF_COUNT_LOW, (k == 1) ? 8'h05 : 8'h00);
    end
    wr(STC_OFF_CONTROL, 8'h05);
    wr(STC_OFF_COUNT_LOW, 8'h00);
    repeat (400) @(posedge i_clock);
    i_addr <= STC_OFF_COUNT_LOW;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 check({7'h0, o_rdata >= 8'd99 && o_rdata <= 8'd102}, 8'h01);
    @(posedge i_clock);
    wr(STC_OFF_CONTROL, 8'h17);
    wr(STC_OFF_COUNT_LOW, 8'h00);
    i_src.pulses(1, 1'b0, 2);
    wr(STC_OFF_COUNT_HI, 8'h00);
    i_src.pulses(1, 1'b0, 2);
    rdchk(STC_OFF_COUNT_LOW, 8'h01);
    i_src.pulses(1, 1'b0, 2);
    wr(STC_OFF_COUNT_LOW, 8'h00);
    i_src.pulses(1, 1'b0, 2);
    rdchk(STC_OFF_COUNT_LOW, 8'h00);
    wr(STC_OFF_CONTROL, 8'h80);
    wr(STC_OFF_COUNT_HI, 8'h12);
    wr(STC_OFF_COUNT_LOW, 8'h34);
    wr(STC_OFF_COUNT_HI, 8'h56);
    rdchk(STC_OFF_COUNT_HI, 8'h56);
    rdchk(STC_OFF_COUNT_LOW, 8'h34);
    rdchk(STC_OFF_COUNT_HI, 8'h12);
    wr(STC_OFF_CONTROL, 8'h00);
    wr(STC_OFF_COUNT_HI, 8'hff);
    rdchk(STC_OFF_COUNT_HI, 8'hff);
    wr(STC_OFF_COUNT_LOW, 8'hfe);
    wr(STC_OFF_CONTROL, 8'h07);
    i_src.pulses(2, 1'b0, 2);
    rdchk(STC_OFF_COUNT_HI, 8'h00);
    rdchk(STC_OFF_FLAGS, 8'h01);
    check({7'h0, o_irq}, 8'h00);
    wr(STC_OFF_ENABLES, 8'h01);
    check({7'h0, o_irq}, 8'h01);
    rdchk(STC_OFF_ENABLES, 8'h01);
    rdchk(STC_OFF_FLAGS, 8'h01);
    wr(STC_OFF_FLAGS, 8'h01);
    check({7'h0, o_irq}, 8'h00);
    i_src.hold(1'b1, 1'b1);
    rdchk(STC_OFF_PORT_IN, 8'h00);
    wr(STC_OFF_PORT_DIR, 8'h00);
    check({6'h0, o_pin_oe}, 8'h00);
    wr(STC_OFF_CONTROL, 8'h00);
    check({6'h0, o_pin_oe}, 8'h03);
    rdchk(STC_OFF_PORT_IN, 8'h03);
    i_src.hold(1'b0, 1'b0);
    wr(STC_OFF_CONTROL, 8'hbf);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    rdchk(STC_OFF_CONTROL, STC_CONTROL_RESET);
    check({6'h0, o_osc_run, o_sys_clk_from_aux}, 8'h00);
    conclude();
  end
endmodule // testbench
